// File: core/sse_exec.sv
// execution slice: three subtracts and sleep, apb register access
// Functional notes
// - literal subtract computes literal minus accumulator into the accumulator.
// - after literal subtract carry and nibble carry are 1 unless accumulator exceeds literal.
// - sleep clears watchdog and prescaler, sets timeout flag, clears powerdown flag.
// - after sleep the core enters sleep with the oscillator halted.
// - file subtract computes file minus accumulator; dest 0 to accumulator, 1 to file.
// - after file subtract carry and nibble carry are 1 unless accumulator exceeds file value.
// - borrow subtract removes accumulator and inverted carry from the file value.
// - an instruction takes four oscillator periods.
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/1ns
module sse_exec
    import sse_pkg::*;
#(
    parameter int unsigned FILE_DEPTH = 128
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        wake,
    output logic             osc_run,
    output logic             sleeping,
    output logic [7:0]       watchdog_counter
);
    if (FILE_DEPTH < 1 || FILE_DEPTH > 128) begin : g_depth_bad
        $error("FILE_DEPTH must be 1..128");
    end

    sse_state_t s_ff;
    sse_state_t nxt_s;
    logic [7:0] file_ff [FILE_DEPTH];
    logic [6:0] faddr_ff;
    logic [6:0] nxt_faddr;

    function automatic sse_alu_t sub_f(input logic [7:0] a, input logic [7:0] w,
                                       input logic b_in);
        sse_alu_t r;
        logic [8:0] full;
        logic [4:0] low;
        full     = {1'b0, a} + {1'b0, ~w} + {8'h00, b_in};
        low      = {1'b0, a[3:0]} + {1'b0, ~w[3:0]} + {4'h0, b_in};
        r.res    = full[7:0];
        r.carry  = full[8];
        r.nibble = low[4];
        r.zero   = (full[7:0] == 8'h00);
        return r;
    endfunction

    wire logic acc_w   = psel && penable && pwrite;
    // read data captured in setup, shown from flops in access
    wire logic acc_r   = psel && !penable && !pwrite;
    wire logic hit_f   = (paddr >= ADDR_FILE) && (paddr <= ADDR_FILE_END);
    wire logic [6:0] fidx = paddr[8:2];
    wire logic file_ok = hit_f && (paddr[1:0] == 2'b00) && (32'(fidx) < FILE_DEPTH);
    wire logic hit_ok  = (paddr[1:0] == 2'b00) && ((paddr == ADDR_CTRL)
                         || (paddr == ADDR_ACC) || (paddr == ADDR_STATUS) || file_ok);
    wire logic busy    = (s_ff.st != SSE_IDLE);
    wire logic issue   = acc_w && (paddr == ADDR_CTRL) && !busy;
    wire logic [7:0] fval = file_ff[faddr_ff];

    sse_alu_t alu;
    logic     wr_file;

    always_comb begin
        nxt_s     = s_ff;
        nxt_faddr = faddr_ff;
        wr_file   = 1'b0;
        alu       = sub_f(8'h00, 8'h00, 1'b1);
        nxt_s.prdata = 32'h0000_0000;
        case (s_ff.op)
            SSE_OP_LIT:  alu = sub_f(s_ff.operand, s_ff.acc, 1'b1);
            SSE_OP_FILE: alu = sub_f(fval, s_ff.acc, 1'b1);
            SSE_OP_BORR: alu = sub_f(fval, s_ff.acc, s_ff.status[ST_CARRY]);
            default:     alu = sub_f(8'h00, 8'h00, 1'b1);
        endcase
        case (s_ff.st)
            SSE_IDLE: begin
                if (issue) begin
                    nxt_s.op      = sse_op_t'(pwdata[17:16]);
                    nxt_s.dest    = pwdata[15];
                    nxt_s.operand = pwdata[7:0];
                    nxt_faddr     = pwdata[14:8];
                    nxt_s.phase   = 2'h0;
                    nxt_s.st      = SSE_EXEC;
                end
            end
            SSE_EXEC: begin
                nxt_s.phase = s_ff.phase + 2'h1;
                if (s_ff.phase == PHASE_LAST) begin
                    nxt_s.st = SSE_IDLE;
                    if (s_ff.op == SSE_OP_SLP) begin
                        nxt_s.wdog               = WDOG_CLEAR;
                        nxt_s.wdog_pre           = WDOG_CLEAR;
                        nxt_s.status[ST_TOUT]    = 1'b1;
                        nxt_s.status[ST_PDOWN]   = 1'b0;
                        nxt_s.status[ST_SLEEP]   = 1'b1;
                        nxt_s.osc_run            = 1'b0;
                        nxt_s.st                 = SSE_SLEEP;
                    end else begin
                        // only the three arithmetic flags move
                        nxt_s.status[ST_CARRY]  = alu.carry;
                        nxt_s.status[ST_NIBBLE] = alu.nibble;
                        nxt_s.status[ST_ZERO]   = alu.zero;
                        if (s_ff.op == SSE_OP_LIT || !s_ff.dest) begin
                            nxt_s.acc = alu.res;
                        end else begin
                            wr_file = 1'b1;
                        end
                    end
                end
            end
            SSE_SLEEP: begin
                if (wake) begin
                    nxt_s.st             = SSE_IDLE;
                    nxt_s.osc_run        = 1'b1;
                    nxt_s.status[ST_SLEEP] = 1'b0;
                end
            end
            default: nxt_s.st = SSE_IDLE;
        endcase
        if (s_ff.st == SSE_IDLE && s_ff.osc_run) begin
            {nxt_s.wdog, nxt_s.wdog_pre} = {s_ff.wdog, s_ff.wdog_pre} + 16'h0001;
        end
        if (acc_w && !busy && paddr == ADDR_ACC) begin
            nxt_s.acc = pwdata[7:0];
        end
        if (acc_r) begin
            if (paddr == ADDR_ACC) begin
                nxt_s.prdata = {24'h00_0000, s_ff.acc};
            end else if (paddr == ADDR_STATUS) begin
                nxt_s.prdata = {24'h00_0000, s_ff.status[7:ST_BUSY+1], busy,
                                s_ff.status[ST_SLEEP:0]};
            end else if (file_ok) begin
                nxt_s.prdata = {24'h00_0000, file_ff[fidx]};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_ff     <= '{st: SSE_IDLE, phase: 2'h0, op: SSE_OP_LIT, operand: 8'h00,
                          dest: 1'b0, acc: 8'h00, status: STATUS_RESET, wdog: 8'h00,
                          wdog_pre: 8'h00, prdata: 32'h0000_0000, osc_run: 1'b1};
            faddr_ff <= 7'h00;
        end else begin
            s_ff     <= nxt_s;
            faddr_ff <= nxt_faddr;
        end
    end

    // file memory, no reset
    always_ff @(posedge pclk) begin
        if (wr_file) begin
            file_ff[faddr_ff] <= alu.res;
        end else if (acc_w && !busy && file_ok) begin
            file_ff[fidx] <= pwdata[7:0];
        end
    end

    assign pready           = 1'b1;
    assign pslverr          = psel && penable && !hit_ok;
    assign prdata           = s_ff.prdata;
    assign osc_run          = s_ff.osc_run;
    assign sleeping         = (s_ff.st == SSE_SLEEP);
    assign watchdog_counter = s_ff.wdog;

    // reference result built from plain subtraction, not the adder chain
    wire logic [7:0] exp_res = ((s_ff.op == SSE_OP_LIT) ? s_ff.operand : fval) - s_ff.acc
                               - {7'h00, (s_ff.op == SSE_OP_BORR) && !s_ff.status[ST_CARRY]};

    sequence issue_seq;
        (s_ff.st == SSE_IDLE) && issue;
    endsequence

    sequence lit_end_seq;
        (s_ff.st == SSE_EXEC) && (s_ff.phase == PHASE_LAST) && (s_ff.op == SSE_OP_LIT);
    endsequence

    sequence file_end_seq;
        (s_ff.st == SSE_EXEC) && (s_ff.phase == PHASE_LAST) && (s_ff.op == SSE_OP_FILE);
    endsequence

    sequence borr_end_seq;
        (s_ff.st == SSE_EXEC) && (s_ff.phase == PHASE_LAST) && (s_ff.op == SSE_OP_BORR);
    endsequence

    sequence slp_end_seq;
        (s_ff.st == SSE_EXEC) && (s_ff.phase == PHASE_LAST) && (s_ff.op == SSE_OP_SLP);
    endsequence

    sequence doze_seq;
        (s_ff.st == SSE_SLEEP) && !wake;
    endsequence

    a_cycle_four_phases: assert property (@(posedge pclk) disable iff (!presetn)
        issue_seq |=> (s_ff.st == SSE_EXEC)[*4] ##1 (s_ff.st != SSE_EXEC))
        else $error("instruction not four cycles");
    a_sleep_flags_set: assert property (@(posedge pclk) disable iff (!presetn)
        (s_ff.st == SSE_EXEC && s_ff.phase == PHASE_LAST && s_ff.op == SSE_OP_SLP)
        |=> s_ff.status[ST_TOUT] && !s_ff.status[ST_PDOWN] && s_ff.wdog == WDOG_CLEAR
            && s_ff.wdog_pre == WDOG_CLEAR)
        else $error("sleep flags wrong");
    a_sleep_osc_off: assert property (@(posedge pclk) disable iff (!presetn)
        (s_ff.st == SSE_SLEEP) |-> !osc_run)
        else $error("oscillator running in sleep");
    a_zero_flag_res: assert property (@(posedge pclk) disable iff (!presetn)
        (s_ff.st == SSE_EXEC && s_ff.phase == PHASE_LAST && s_ff.op != SSE_OP_SLP)
        |=> s_ff.status[ST_ZERO] == ($past(exp_res) == 8'h00))
        else $error("zero flag wrong");
    a_lit_acc_result: assert property (@(posedge pclk) disable iff (!presetn)
        (s_ff.st == SSE_EXEC && s_ff.phase == PHASE_LAST && s_ff.op == SSE_OP_LIT)
        |=> s_ff.acc == 8'($past(s_ff.operand) - $past(s_ff.acc)))
        else $error("literal result wrong");
    a_lit_carry_cmp: assert property (@(posedge pclk) disable iff (!presetn)
        (s_ff.st == SSE_EXEC && s_ff.phase == PHASE_LAST && s_ff.op == SSE_OP_LIT)
        |=> s_ff.status[ST_CARRY] == ($past(s_ff.acc) <= $past(s_ff.operand))
            && s_ff.status[ST_NIBBLE] == ($past(s_ff.acc[3:0]) <= $past(s_ff.operand[3:0])))
        else $error("literal carry wrong");
    a_file_carry_cmp: assert property (@(posedge pclk) disable iff (!presetn)
        (s_ff.st == SSE_EXEC && s_ff.phase == PHASE_LAST && s_ff.op == SSE_OP_FILE)
        |=> s_ff.status[ST_CARRY] == ($past(s_ff.acc) <= $past(fval))
            && s_ff.status[ST_NIBBLE] == ($past(s_ff.acc[3:0]) <= $past(fval[3:0])))
        else $error("file carry wrong");
    a_file_dest_acc: assert property (@(posedge pclk) disable iff (!presetn)
        (s_ff.st == SSE_EXEC && s_ff.phase == PHASE_LAST && s_ff.op == SSE_OP_FILE
         && !s_ff.dest) |=> s_ff.acc == 8'($past(fval) - $past(s_ff.acc)))
        else $error("file result wrong");
    a_borrow_result: assert property (@(posedge pclk) disable iff (!presetn)
        (s_ff.st == SSE_EXEC && s_ff.phase == PHASE_LAST && s_ff.op == SSE_OP_BORR
         && !s_ff.dest) |=> s_ff.acc == 8'($past(fval) - $past(s_ff.acc)
                                          - {7'h00, !$past(s_ff.status[ST_CARRY])}))
        else $error("borrow result wrong");
    a_other_bits_kept: assert property (@(posedge pclk) disable iff (!presetn)
        (s_ff.st == SSE_EXEC && s_ff.op != SSE_OP_SLP)
        |=> s_ff.status[7:3] == $past(s_ff.status[7:3]))
        else $error("subtract touched other status");

    // results written back to the file register, and no write for literal or accumulator destination
    a_file_dest_file: assert property (@(posedge pclk) disable iff (!presetn)
        file_end_seq ##0 s_ff.dest
        |=> file_ff[$past(faddr_ff)] == 8'($past(fval) - $past(s_ff.acc))
            && s_ff.acc == $past(s_ff.acc))
        else $error("file result not stored back");

    a_borrow_dest_file: assert property (@(posedge pclk) disable iff (!presetn)
        borr_end_seq ##0 s_ff.dest
        |=> file_ff[$past(faddr_ff)] == 8'($past(fval) - $past(s_ff.acc)
                                          - {7'h00, !$past(s_ff.status[ST_CARRY])})
            && s_ff.acc == $past(s_ff.acc))
        else $error("borrow result not stored back");

    a_lit_no_file: assert property (@(posedge pclk) disable iff (!presetn)
        lit_end_seq |-> !wr_file)
        else $error("literal subtract wrote a file register");

    a_file_acc_only: assert property (@(posedge pclk) disable iff (!presetn)
        file_end_seq ##0 !s_ff.dest |-> !wr_file)
        else $error("file subtract to accumulator wrote a file register");

    // sleep entry, stay and exit
    a_sleep_osc_halt: assert property (@(posedge pclk) disable iff (!presetn)
        slp_end_seq |=> sleeping && !osc_run)
        else $error("sleep not entered");

    a_sleep_arith_kept: assert property (@(posedge pclk) disable iff (!presetn)
        slp_end_seq
        |=> s_ff.status[ST_ZERO:ST_CARRY] == $past(s_ff.status[ST_ZERO:ST_CARRY]))
        else $error("sleep touched arithmetic flags");

    a_sleep_no_write: assert property (@(posedge pclk) disable iff (!presetn)
        slp_end_seq |-> !wr_file ##1 s_ff.acc == $past(s_ff.acc))
        else $error("sleep wrote a result");

    a_doze_held: assert property (@(posedge pclk) disable iff (!presetn)
        doze_seq |=> sleeping && !osc_run && s_ff.status[ST_SLEEP])
        else $error("sleep left without wake");

    a_doze_wdog_still: assert property (@(posedge pclk) disable iff (!presetn)
        doze_seq |=> watchdog_counter == WDOG_CLEAR && s_ff.wdog_pre == WDOG_CLEAR)
        else $error("watchdog moved in sleep");

    a_wake_resume: assert property (@(posedge pclk) disable iff (!presetn)
        (s_ff.st == SSE_SLEEP) && wake |=> !sleeping && osc_run)
        else $error("wake did not restart the core");

    // the four phases of one instruction
    a_phase_step: assert property (@(posedge pclk) disable iff (!presetn)
        (s_ff.st == SSE_EXEC) && (s_ff.phase != PHASE_LAST)
        |=> (s_ff.st == SSE_EXEC) && (s_ff.phase == 2'($past(s_ff.phase) + 2'h1)))
        else $error("execution phase skipped");

    a_exec_op_held: assert property (@(posedge pclk) disable iff (!presetn)
        (s_ff.st == SSE_EXEC) && (s_ff.phase != PHASE_LAST)
        |=> $stable(s_ff.op) && $stable(s_ff.operand)
            && $stable(faddr_ff) && $stable(s_ff.dest))
        else $error("instruction changed while executing");
endmodule // sse_exec

// File: core/sse_pkg.sv
// package for the subtract and sleep execution slice
package sse_pkg;
    localparam int unsigned OSC_PER_CYCLE = 4;
    localparam logic [1:0] PHASE_LAST = 2'h3;
    localparam logic [7:0] WDOG_CLEAR = 8'h00;

    // register byte addresses
    localparam logic [11:0] ADDR_CTRL   = 12'h000;
    localparam logic [11:0] ADDR_ACC    = 12'h004;
    localparam logic [11:0] ADDR_STATUS = 12'h008;
    localparam logic [11:0] ADDR_FILE   = 12'h200;
    localparam logic [11:0] ADDR_FILE_END = 12'h3fc;

    // status bit positions
    localparam int unsigned ST_CARRY  = 0;
    localparam int unsigned ST_NIBBLE = 1;
    localparam int unsigned ST_ZERO   = 2;
    localparam int unsigned ST_PDOWN  = 3;
    localparam int unsigned ST_TOUT   = 4;
    localparam int unsigned ST_SLEEP  = 5;
    localparam int unsigned ST_BUSY   = 6;
    localparam logic [7:0] STATUS_RESET = 8'h18;

    typedef enum logic [1:0] {
        SSE_OP_LIT  = 2'b00,
        SSE_OP_FILE = 2'b01,
        SSE_OP_BORR = 2'b10,
        SSE_OP_SLP  = 2'b11
    } sse_op_t;

    typedef enum logic [1:0] {
        SSE_IDLE  = 2'b00,
        SSE_EXEC  = 2'b01,
        SSE_SLEEP = 2'b10
    } sse_st_t;

    typedef struct packed {
        logic [7:0] res;
        logic       carry;
        logic       nibble;
        logic       zero;
    } sse_alu_t;

    typedef struct packed {
        sse_st_t    st;
        logic [1:0] phase;
        sse_op_t    op;
        logic [7:0] operand;
        logic       dest;
        logic [7:0] acc;
        logic [7:0] status;
        logic [7:0] wdog;
        logic [7:0] wdog_pre;
        logic [31:0] prdata;
        logic       osc_run;
    } sse_state_t;
endpackage : sse_pkg

// File: sim/sse_exec_bench.sv
// self-checking bench for the subtract and sleep execution slice
`timescale 1ns/1ns
module subtract_and_sleep_exec_bench
    import sse_pkg::*;
;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        wake;
    logic        osc_run;
    logic        sleeping;
    logic [7:0]  watchdog_counter;
    int          num_errors;
    int          checks;
    logic        ec, epd, eto;
    logic [31:0] r;

    sse_exec uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .wake(wake), .osc_run(osc_run), .sleeping(sleeping),
        .watchdog_counter(watchdog_counter));

    always #50 pclk = ~pclk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        int n;
        n = 0;
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) chk(32'h0000_0000, 32'h0000_0001);
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] q);
        logic e;
        apb(1'b0, a, 32'h0000_0000, q, e);
    endtask

    // one subtract with bench-side expectations
    task automatic sub_case(input sse_op_t o, input logic d, input logic [6:0] f,
                            input logic [7:0] k, input logic [7:0] a, input logic [7:0] fv);
        logic [8:0] s;
        logic [4:0] h;
        logic [7:0] x;
        logic       ci;
        int         n;
        wr(ADDR_ACC, {24'h0, a});
        wr(ADDR_FILE + {3'h0, f, 2'b00}, {24'h0, fv});
        wr(ADDR_CTRL, {14'h0, o, d, f, k});
        n = 0;
        do begin
            rd(ADDR_STATUS, r);
            n++;
        end while (r[ST_BUSY] !== 1'b0 && n < 50);
        x = (o == SSE_OP_LIT) ? k : fv;
        ci = (o == SSE_OP_BORR) ? ec : 1'b1;
        s = {1'b0, x} + {1'b0, ~a} + {8'h0, ci};
        h = {1'b0, x[3:0]} + {1'b0, ~a[3:0]} + {4'h0, ci};
        if (o != SSE_OP_BORR) begin
            s[8] = (a <= x);
            h[4] = (a[3:0] <= x[3:0]);
        end
        ec = s[8];
        chk(r, {27'h0, eto, epd, s[7:0] == 8'h00, h[4], s[8]});
        rd(ADDR_ACC, r);
        chk(r, {24'h0, (o == SSE_OP_LIT || !d) ? s[7:0] : a});
        rd(ADDR_FILE + {3'h0, f, 2'b00}, r);
        chk(r, {24'h0, (o != SSE_OP_LIT && d) ? s[7:0] : fv});
    endtask

    task automatic sleep_case();
        int n;
        repeat (600) @(posedge pclk);
        chk({31'h0, watchdog_counter != 8'h00}, 32'h0000_0001);
        wr(ADDR_CTRL, {14'h0, SSE_OP_SLP, 16'h0000});
        // taking edge lies one edge before wr returns
        n = 1;
        @(negedge pclk);
        while (sleeping !== 1'b1 && n < 20) begin
            @(negedge pclk);
            n++;
        end
        chk(n, OSC_PER_CYCLE);
        chk({osc_run, watchdog_counter}, {1'b0, WDOG_CLEAR});
        repeat (3) @(negedge pclk);
        chk(sleeping, 1'b1);
        epd = 1'b0;
        eto = 1'b1;
        @(posedge pclk);
        wake <= 1'b1;
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (sleeping !== 1'b0 && n < 20);
        @(posedge pclk);
        wake <= 1'b0;
        rd(ADDR_STATUS, r);
        chk(r[6:3], {2'b00, eto, epd});
        chk(osc_run, 1'b1);
    endtask

    task automatic report_and_stop();
        if (num_errors == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        #3_000_000;
        num_errors++;
        report_and_stop();
    end

    initial begin
        logic [31:0] q;
        logic        e;
        pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0000_0000; wake = 1'b0;
        num_errors = 0; checks = 0; ec = 1'b0; epd = 1'b1; eto = 1'b1;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd(ADDR_STATUS, r);
        chk(r, {24'h0, STATUS_RESET});
        apb(1'b0, 12'h100, 32'h0000_0000, q, e);
        chk(e, 1'b1);
        sub_case(SSE_OP_LIT, 1'b0, 7'h00, 8'h03, 8'h05, 8'h00);
        sub_case(SSE_OP_LIT, 1'b0, 7'h00, 8'h10, 8'h10, 8'h00);
        sub_case(SSE_OP_FILE, 1'b1, 7'h7f, 8'h00, 8'h01, 8'h20);
        sub_case(SSE_OP_FILE, 1'b0, 7'h05, 8'h00, 8'h0f, 8'h0e);
        sub_case(SSE_OP_BORR, 1'b1, 7'h01, 8'h00, 8'h0f, 8'h10);
        sub_case(SSE_OP_BORR, 1'b0, 7'h7f, 8'h00, 8'h01, 8'h03);
        sleep_case();
        report_and_stop();
    end
endmodule // subtract_and_sleep_exec_bench
